// file: tfc_pkg.sv
package tfc_pkg;
  // Special-function register addresses
  localparam logic [7:0] ADDR_IRQ_ENABLE_ONE   = 8'hA9;
  localparam logic [7:0] ADDR_IRQ_PRIORITY_ONE = 8'hB9;
  localparam logic [7:0] ADDR_CONTROL          = 8'hC8;
  localparam logic [7:0] ADDR_MODE             = 8'hC9;
  localparam logic [7:0] ADDR_RELOAD_LOW       = 8'hCA;
  localparam logic [7:0] ADDR_RELOAD_HIGH      = 8'hCB;
  localparam logic [7:0] ADDR_COUNT_LOW        = 8'hCC;
  localparam logic [7:0] ADDR_COUNT_HIGH       = 8'hCD;
  localparam logic [7:0] ADDR_BANK_POINTER     = 8'hCE;

  localparam logic [2:0] BANK_THIS_TIMER   = 3'h4;
  localparam logic [2:0] BANK_POINTER_RST  = 3'h2;

  // Control register fields
  localparam int CTL_OVF   = 7;
  localparam int CTL_EXF   = 6;
  localparam int CTL_EXEN  = 3;
  localparam int CTL_RUN   = 2;
  localparam int CTL_CNT   = 1;
  localparam int CTL_CAP   = 0;
  localparam logic [7:0] CTL_WMASK = 8'hCF;

  // Mode register fields
  localparam int MOD_BYP   = 7;
  localparam int MOD_CKOE  = 1;
  localparam int MOD_UPDN  = 0;
  localparam logic [7:0] MOD_WMASK = 8'hBF;

  // Interrupt enable and priority bit for this timer
  localparam int IRQ_BIT = 7;

  localparam logic [7:0]  REG_RST      = 8'h00;
  localparam logic [15:0] COUNT_MAX    = 16'hFFFF;
  localparam logic [3:0]  PRESCALE_DIV = 4'hC;
  localparam logic [3:0]  PRESCALE_TOP = 4'hB;
  localparam logic [1:0]  SYNC_RST     = 2'h3;
endpackage

// file: tfc_edge_sync.sv
`timescale 1ns/10ps
module tfc_edge_sync
  import tfc_pkg::*;
(
  input  wire logic clk,      // System clock
  input  wire logic rst,      // Async reset, active high
  input  wire logic pin,      // Raw pin level
  output logic      level,    // Synchronised level
  output logic      fall      // One-cycle falling-edge pulse
);
  logic [1:0] sync_q;
  logic       last_q;

  // Pins idle high so no false edge appears after reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync_q <= SYNC_RST;
      last_q <= 1'b1;
    end else begin
      sync_q <= {sync_q[0], pin};
      last_q <= sync_q[1];
    end
  end

  assign level = sync_q[1];
  assign fall  = last_q & ~sync_q[1];
endmodule // tfc_edge_sync

// file: tfc_prescale.sv
`timescale 1ns/10ps
module tfc_prescale
  import tfc_pkg::*;
(
  input  wire logic clk,      // System clock
  input  wire logic rst,      // Async reset, active high
  input  wire logic run,      // Divider runs only while timer runs
  input  wire logic bypass,   // 1: every cycle ticks
  output logic      tick      // Count-enable pulse
);
  logic [3:0] div_q;
  logic [3:0] div_d;
  logic       wrap;

  assign wrap  = (div_q == PRESCALE_TOP);
  assign div_d = (!run || wrap) ? 4'h0 : div_q + 4'h1;
  assign tick  = run & (bypass | wrap);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) div_q <= 4'h0;
    else     div_q <= div_d;
  end
endmodule // tfc_prescale

// file: tfc_timer.sv
`timescale 1ns/10ps
// Behaviour
// - Count advances only while run control is 1; PWM counter stops too.
// - Timer mode ticks at fsys/12, or fsys when prescale bypass is set.
// - Control and mode addresses reach this timer only when pointer is 100.
// - Overflow sets control bit 7 unless clock output is on; only software writes clear it.
// - Trigger falling edge sets bit 6 when trigger enabled, except in up/down mode; software clears.
// - Bit 3 zero ignores trigger edges; one makes edge capture or reload, except in up/down mode.
// - Bit 2 starts or stops both timer and PWM counter.
// - Bit 1 picks internal ticks or count-pin events; clock output forces internal ticks.
// - Bit 0 picks reload (0) or capture (1) with trigger as capture input.
// - Mode bit 1 drives count pin as clock output.
// - Mode bit 0 allows up/down in reload mode, with trigger level as direction.
// - Enable register bit 7 gates this timer's interrupt request.
// - Priority register bit 7 gives low or high interrupt priority.
// - Up-count overflow sets flag (not with clock output) and in reload mode loads the reload value; capture mode rolls to 0.
// - Capture mode edge copies count into capture registers.
// - Interrupt when global and own enable set and any flag set.
module tfc_timer
  import tfc_pkg::*;
(
  input  wire logic       SYS_CLK,      // System clock, 125 MHz
  input  wire logic       RST,          // Async reset, active high
  input  wire logic [7:0] SFR_ADDR,     // Register address
  input  wire logic [7:0] SFR_WDATA,    // Write data
  input  wire logic       SFR_WR,       // Write strobe
  input  wire logic       SFR_RD,       // Read strobe
  output logic      [7:0] SFR_RDATA,    // Read data, registered
  output logic            SFR_HIT,      // Address belongs to this block
  input  wire logic       GLOBAL_IRQ_ENABLE, // CPU-wide interrupt enable
  input  wire logic       COUNT_PIN_IN, // Count pin level
  output logic            COUNT_PIN_OUT,// Clock output level
  output logic            COUNT_PIN_OE, // Count pin driven
  input  wire logic       EXT_TRIGGER_PIN, // Trigger pin level
  output logic            IRQ_REQ,      // Interrupt request
  output logic            IRQ_HIGH_PRIO,// Request has high priority
  output logic            PWM_COUNT_RUN,// Shared PWM counter runs
  output logic     [15:0] COUNT_VALUE   // Current count
);
  logic [7:0]  ctl_q, ctl_d, mod_q, mod_d, ie_q, ie_d, ip_q, ip_d;
  logic [15:0] cnt_q, cnt_d, rcap_q, rcap_d;
  logic [2:0]  bank_q, bank_d;
  logic [7:0]  rdata_q, rdata_d;
  logic        ckout_q, ckout_d;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    hit = (a == r);
  endfunction

  logic sel_bank, wr_ctl, wr_mod, wr_ie, wr_ip, wr_bank;
  logic wr_rl, wr_rh, wr_cl, wr_ch, banked;
  assign sel_bank = (bank_q == BANK_THIS_TIMER);
  assign banked   = hit(SFR_ADDR, ADDR_CONTROL) | hit(SFR_ADDR, ADDR_MODE)
                  | hit(SFR_ADDR, ADDR_RELOAD_LOW)
                  | hit(SFR_ADDR, ADDR_RELOAD_HIGH)
                  | hit(SFR_ADDR, ADDR_COUNT_LOW)
                  | hit(SFR_ADDR, ADDR_COUNT_HIGH);
  assign wr_ctl  = SFR_WR & sel_bank & hit(SFR_ADDR, ADDR_CONTROL);
  assign wr_mod  = SFR_WR & sel_bank & hit(SFR_ADDR, ADDR_MODE);
  assign wr_rl   = SFR_WR & sel_bank & hit(SFR_ADDR, ADDR_RELOAD_LOW);
  assign wr_rh   = SFR_WR & sel_bank & hit(SFR_ADDR, ADDR_RELOAD_HIGH);
  assign wr_cl   = SFR_WR & sel_bank & hit(SFR_ADDR, ADDR_COUNT_LOW);
  assign wr_ch   = SFR_WR & sel_bank & hit(SFR_ADDR, ADDR_COUNT_HIGH);
  assign wr_ie   = SFR_WR & hit(SFR_ADDR, ADDR_IRQ_ENABLE_ONE);
  assign wr_ip   = SFR_WR & hit(SFR_ADDR, ADDR_IRQ_PRIORITY_ONE);
  assign wr_bank = SFR_WR & hit(SFR_ADDR, ADDR_BANK_POINTER);
  assign SFR_HIT = (banked & sel_bank) | hit(SFR_ADDR, ADDR_BANK_POINTER)
                 | hit(SFR_ADDR, ADDR_IRQ_ENABLE_ONE)
                 | hit(SFR_ADDR, ADDR_IRQ_PRIORITY_ONE);

  // ----------------------------------------------------------------
  // Pin conditioning
  // ----------------------------------------------------------------
  logic trig_lvl, trig_fall, cpin_fall;
  tfc_edge_sync u_trig (
    .clk   (SYS_CLK),
    .rst   (RST),
    .pin   (EXT_TRIGGER_PIN),
    .level (trig_lvl),
    .fall  (trig_fall)
  );
  tfc_edge_sync u_cpin (
    .clk   (SYS_CLK),
    .rst   (RST),
    .pin   (COUNT_PIN_IN),
    .level (),
    .fall  (cpin_fall)
  );

  // ----------------------------------------------------------------
  // Count source
  // ----------------------------------------------------------------
  logic run, pre_tick, tick;
  assign run = ctl_q[CTL_RUN];
  tfc_prescale u_pre (
    .clk    (SYS_CLK),
    .rst    (RST),
    .run    (run),
    .bypass (mod_q[MOD_BYP]),
    .tick   (pre_tick)
  );
  // Clock output needs internal ticks, so counter mode is overridden
  assign tick = (ctl_q[CTL_CNT] && !mod_q[MOD_CKOE])
              ? (run & cpin_fall) : pre_tick;
  assign PWM_COUNT_RUN = run;

  // ----------------------------------------------------------------
  // Count, reload and capture
  // ----------------------------------------------------------------
  logic updn, count_up, exen, capmode, ovf_up, ovf_dn, ovf, ext_evt;
  assign updn     = mod_q[MOD_UPDN] & ~ctl_q[CTL_CAP];
  assign count_up = ~updn | trig_lvl;
  assign exen     = ctl_q[CTL_EXEN];
  assign capmode  = ctl_q[CTL_CAP];
  assign ovf_up   = tick & count_up & (cnt_q == COUNT_MAX);
  assign ovf_dn   = tick & ~count_up & (cnt_q == rcap_q);
  assign ovf      = ovf_up | ovf_dn;
  // Direction mode uses the trigger as a level, so edges do nothing there
  assign ext_evt  = exen & trig_fall & ~updn;

  always_comb begin
    cnt_d  = cnt_q;
    rcap_d = rcap_q;
    if (ovf_up && !capmode)       cnt_d = rcap_q;
    else if (ovf_dn)              cnt_d = COUNT_MAX;
    else if (ext_evt && !capmode) cnt_d = rcap_q;
    else if (tick && count_up)    cnt_d = cnt_q + 16'h0001;
    else if (tick)                cnt_d = cnt_q - 16'h0001;
    if (ext_evt && capmode)       rcap_d = cnt_q;
    if (wr_cl) cnt_d[7:0]   = SFR_WDATA;
    if (wr_ch) cnt_d[15:8]  = SFR_WDATA;
    if (wr_rl) rcap_d[7:0]  = SFR_WDATA;
    if (wr_rh) rcap_d[15:8] = SFR_WDATA;
  end

  // ----------------------------------------------------------------
  // Control and flags; hardware set wins over software clear
  // ----------------------------------------------------------------
  always_comb begin
    ctl_d = ctl_q;
    if (wr_ctl) ctl_d = SFR_WDATA & CTL_WMASK;
    if (ovf && !mod_q[MOD_CKOE]) ctl_d[CTL_OVF] = 1'b1;
    if (ext_evt) ctl_d[CTL_EXF] = 1'b1;
  end
  assign mod_d  = wr_mod  ? (SFR_WDATA & MOD_WMASK) : mod_q;
  assign ie_d   = wr_ie   ? SFR_WDATA : ie_q;
  assign ip_d   = wr_ip   ? SFR_WDATA : ip_q;
  assign bank_d = wr_bank ? SFR_WDATA[2:0] : bank_q;

  // Clock output toggles on each overflow: 50 % duty
  assign ckout_d = (mod_q[MOD_CKOE] && ovf) ? ~ckout_q : ckout_q;
  assign COUNT_PIN_OUT = ckout_q;
  assign COUNT_PIN_OE  = mod_q[MOD_CKOE];

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  always_comb begin
    rdata_d = rdata_q;
    if (SFR_RD) begin
      rdata_d = REG_RST;
      if (hit(SFR_ADDR, ADDR_IRQ_ENABLE_ONE))   rdata_d = ie_q;
      if (hit(SFR_ADDR, ADDR_IRQ_PRIORITY_ONE)) rdata_d = ip_q;
      if (hit(SFR_ADDR, ADDR_BANK_POINTER))     rdata_d = {5'h00, bank_q};
      if (sel_bank) begin
        if (hit(SFR_ADDR, ADDR_CONTROL))     rdata_d = ctl_q;
        if (hit(SFR_ADDR, ADDR_MODE))        rdata_d = mod_q;
        if (hit(SFR_ADDR, ADDR_RELOAD_LOW))  rdata_d = rcap_q[7:0];
        if (hit(SFR_ADDR, ADDR_RELOAD_HIGH)) rdata_d = rcap_q[15:8];
        if (hit(SFR_ADDR, ADDR_COUNT_LOW))   rdata_d = cnt_q[7:0];
        if (hit(SFR_ADDR, ADDR_COUNT_HIGH))  rdata_d = cnt_q[15:8];
      end
    end
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      ctl_q   <= REG_RST;
      mod_q   <= REG_RST;
      ie_q    <= REG_RST;
      ip_q    <= REG_RST;
      cnt_q   <= 16'h0000;
      rcap_q  <= 16'h0000;
      bank_q  <= BANK_POINTER_RST;
      rdata_q <= REG_RST;
      ckout_q <= 1'b0;
    end else begin
      ctl_q   <= ctl_d;
      mod_q   <= mod_d;
      ie_q    <= ie_d;
      ip_q    <= ip_d;
      cnt_q   <= cnt_d;
      rcap_q  <= rcap_d;
      bank_q  <= bank_d;
      rdata_q <= rdata_d;
      ckout_q <= ckout_d;
    end
  end

  // Flags set by software raise the request as well
  assign IRQ_REQ = GLOBAL_IRQ_ENABLE & ie_q[IRQ_BIT]
                 & (ctl_q[CTL_OVF] | ctl_q[CTL_EXF]);
  assign IRQ_HIGH_PRIO = ip_q[IRQ_BIT];
  assign SFR_RDATA     = rdata_q;
  assign COUNT_VALUE   = cnt_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_hold_stopped: assert property (@(posedge SYS_CLK) disable iff (RST)
    (!run && !ext_evt && !wr_cl && !wr_ch && !wr_ctl)
      |=> $stable(cnt_q))
    else $error("count moved while stopped");
  a_prescale_gap: assert property (@(posedge SYS_CLK) disable iff (RST)
    (pre_tick && !mod_q[MOD_BYP] && run && !wr_mod && !wr_ctl)
      |=> (mod_q[MOD_BYP] || !pre_tick) [*8])
    else $error("prescaled tick too early");
  a_bank_gate: assert property (@(posedge SYS_CLK) disable iff (RST)
    (SFR_WR && hit(SFR_ADDR, ADDR_MODE) && bank_q != BANK_THIS_TIMER)
      |=> $stable(mod_q))
    else $error("mode written outside bank");
  a_ovf_sets: assert property (@(posedge SYS_CLK) disable iff (RST)
    (ovf && !mod_q[MOD_CKOE]) |=> ctl_q[CTL_OVF])
    else $error("overflow flag not set");
  a_exf_sets: assert property (@(posedge SYS_CLK) disable iff (RST)
    ext_evt |=> ctl_q[CTL_EXF])
    else $error("event flag not set");
  a_trig_ignored: assert property (@(posedge SYS_CLK) disable iff (RST)
    (!exen && !wr_ctl) |=> $stable(ctl_q[CTL_EXF]))
    else $error("event flag moved while disabled");
  a_reload_load: assert property (@(posedge SYS_CLK) disable iff (RST)
    (ovf_up && !capmode && !wr_cl && !wr_ch)
      |=> cnt_q == $past(rcap_q))
    else $error("reload value not loaded");
  a_capture_copy: assert property (@(posedge SYS_CLK) disable iff (RST)
    (ext_evt && capmode && !wr_rl && !wr_rh)
      |=> rcap_q == $past(cnt_q))
    else $error("count not captured");
  a_irq_gate: assert property (@(posedge SYS_CLK) disable iff (RST)
    IRQ_REQ |-> (ie_q[IRQ_BIT] && GLOBAL_IRQ_ENABLE))
    else $error("request while disabled");
  a_clkout_pin: assert property (@(posedge SYS_CLK) disable iff (RST)
    (wr_mod && SFR_WDATA[MOD_CKOE]) |=> COUNT_PIN_OE)
    else $error("clock output not enabled");
endmodule // tfc_timer

// file: tfc_pin_model.sv
`timescale 1ns/10ps
// ------------------------------------------------------------
// External pin sources
// ------------------------------------------------------------
module tfc_pin_model (
  input  wire logic trig_level,  // Requested trigger level
  input  wire logic count_level, // Requested count-pin level
  input  wire logic pin_oe,      // Device drives the count pin
  input  wire logic pin_out,     // Device clock output level
  output logic      trig_pin,    // Trigger pin seen by the device
  output logic      count_pin    // Resolved count pin level
);
  assign trig_pin  = trig_level;
  // Outside source backs off while the device drives the pin
  assign count_pin = pin_oe ? pin_out : count_level;
endmodule // tfc_pin_model

// file: tfc_timer_tb.sv
`timescale 1ns/10ps
module tfc_timer_tb
  import tfc_pkg::*;
;
  logic        sys_clk = 1'b0;
  logic        rst     = 1'b1;
  logic [7:0]  sfr_addr = 8'h00;
  logic [7:0]  sfr_wdata = 8'h00;
  logic        sfr_wr  = 1'b0;
  logic        sfr_rd  = 1'b0;
  logic [7:0]  sfr_rdata;
  logic        sfr_hit;
  logic        glb_en  = 1'b0;
  logic        trig_lvl = 1'b1;
  logic        cnt_lvl = 1'b1;
  logic        cnt_pin, trig_pin, pin_out, pin_oe;
  logic        irq_req, irq_high, pwm_count_run;
  logic [15:0] count_value;
  int          bad_count = 0;
  int          tests_run = 0;

  always #4 sys_clk = ~sys_clk;

  tfc_timer tfc_timer_i (.SYS_CLK(sys_clk), .RST(rst), .SFR_ADDR(sfr_addr),
    .SFR_WDATA(sfr_wdata), .SFR_WR(sfr_wr), .SFR_RD(sfr_rd),
    .SFR_RDATA(sfr_rdata), .SFR_HIT(sfr_hit), .GLOBAL_IRQ_ENABLE(glb_en),
    .COUNT_PIN_IN(cnt_pin), .COUNT_PIN_OUT(pin_out), .COUNT_PIN_OE(pin_oe),
    .EXT_TRIGGER_PIN(trig_pin), .IRQ_REQ(irq_req), .IRQ_HIGH_PRIO(irq_high),
    .PWM_COUNT_RUN(pwm_count_run), .COUNT_VALUE(count_value));

  tfc_pin_model tfc_pin_model_i (.trig_level(trig_lvl), .count_level(cnt_lvl),
    .pin_oe(pin_oe), .pin_out(pin_out), .trig_pin(trig_pin),
    .count_pin(cnt_pin));

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [15:0] exp,
                     input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", name, exp, got);
      bad_count++;
    end
  endtask

  // One idle cycle follows every strobe, so calls may run back to back
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge sys_clk);
    sfr_wr = 1'b0;
  endtask

  task automatic rdchk(input string name, input logic [7:0] a,
                       input logic [7:0] exp);
    @(negedge sys_clk);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge sys_clk);
    sfr_rd = 1'b0;
    @(negedge sys_clk);
    chk(name, {8'h00, exp}, {8'h00, sfr_rdata});
  endtask

  task automatic wait_move(input logic [15:0] from, output int n);
    n = 0;
    while (count_value === from && n < 40) begin
      @(negedge sys_clk);
      n++;
    end
    if (n >= 40) begin
      bad_count++;
      test_done();
    end
  endtask

  // Pins keep each level well over the three-cycle minimum
  task automatic pulse(input bit trig);
    @(negedge sys_clk);
    if (trig) trig_lvl = 1'b0; else cnt_lvl = 1'b0;
    repeat (5) @(negedge sys_clk);
    if (trig) trig_lvl = 1'b1; else cnt_lvl = 1'b1;
    repeat (5) @(negedge sys_clk);
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_bank();
    @(negedge sys_clk);
    sfr_addr = ADDR_CONTROL;
    #1 chk("hit off bank", 16'h0000, {15'h0, sfr_hit});
    rdchk("pointer reset", ADDR_BANK_POINTER, 8'h02);
    wr(ADDR_CONTROL, 8'h04);
    chk("run off bank", 16'h0000, {15'h0, pwm_count_run});
    wr(ADDR_BANK_POINTER, 8'h04);
    sfr_addr = ADDR_CONTROL;
    #1 chk("hit on bank", 16'h0001, {15'h0, sfr_hit});
    rdchk("control reset", ADDR_CONTROL, 8'h00);
  endtask

  task automatic t_prescale();
    logic [15:0] v;
    int n;
    wr(ADDR_MODE, 8'h00);
    wr(ADDR_CONTROL, 8'h04);
    chk("pwm run", 16'h0001, {15'h0, pwm_count_run});
    wait_move(count_value, n);
    v = count_value;
    wait_move(v, n);
    chk("tick spacing", 16'd12, 16'(n));
    wr(ADDR_MODE, 8'h80);
    v = count_value;
    @(negedge sys_clk);
    chk("bypass step", v + 16'h0001, count_value);
    wr(ADDR_CONTROL, 8'h00);
    v = count_value;
    repeat (20) @(negedge sys_clk);
    chk("count held", v, count_value);
    chk("pwm stop", 16'h0000, {15'h0, pwm_count_run});
  endtask

  task automatic t_overflow();
    int n;
    wr(ADDR_RELOAD_LOW, 8'hF0);
    wr(ADDR_RELOAD_HIGH, 8'hFF);
    wr(ADDR_COUNT_LOW, 8'hFE);
    wr(ADDR_COUNT_HIGH, 8'hFF);
    wr(ADDR_IRQ_ENABLE_ONE, 8'h80);
    glb_en = 1'b1;
    chk("irq idle", 16'h0000, {15'h0, irq_req});
    wr(ADDR_CONTROL, 8'h04);
    n = 0;
    while (irq_req !== 1'b1 && n < 10) begin
      @(negedge sys_clk);
      n++;
    end
    chk("irq on wrap", 16'h0001, {15'h0, irq_req});
    chk("reload on wrap", 16'hFFF0, count_value);
    if (n >= 10) test_done();
    wr(ADDR_CONTROL, 8'h80);
    rdchk("flag kept", ADDR_CONTROL, 8'h80);
    wr(ADDR_IRQ_ENABLE_ONE, 8'h00);
    chk("irq masked", 16'h0000, {15'h0, irq_req});
    wr(ADDR_IRQ_PRIORITY_ONE, 8'h80);
    chk("high prio", 16'h0001, {15'h0, irq_high});
    wr(ADDR_IRQ_ENABLE_ONE, 8'h80);
    chk("irq unmasked", 16'h0001, {15'h0, irq_req});
    wr(ADDR_CONTROL, 8'h00);
    chk("flag cleared", 16'h0000, {15'h0, irq_req});
  endtask

  task automatic t_capture();
    wr(ADDR_CONTROL, 8'h09);
    wr(ADDR_COUNT_LOW, 8'h34);
    wr(ADDR_COUNT_HIGH, 8'h12);
    pulse(1'b1);
    rdchk("capture low", ADDR_RELOAD_LOW, 8'h34);
    rdchk("capture high", ADDR_RELOAD_HIGH, 8'h12);
    rdchk("event flag", ADDR_CONTROL, 8'h49);
    wr(ADDR_CONTROL, 8'h01);
    pulse(1'b1);
    rdchk("trigger ignored", ADDR_CONTROL, 8'h01);
    wr(ADDR_COUNT_LOW, 8'h00);
    wr(ADDR_COUNT_HIGH, 8'h00);
    wr(ADDR_CONTROL, 8'h08);
    pulse(1'b1);
    chk("trigger reload", 16'h1234, count_value);
    wr(ADDR_CONTROL, 8'h00);
  endtask

  task automatic t_counter();
    logic [15:0] v;
    wr(ADDR_CONTROL, 8'h06);
    v = count_value;
    repeat (3) pulse(1'b0);
    chk("pin events", v + 16'h0003, count_value);
    chk("pin input", 16'h0000, {15'h0, pin_oe});
    wr(ADDR_MODE, 8'h02);
    chk("pin output", 16'h0001, {15'h0, pin_oe});
    wr(ADDR_CONTROL, 8'h00);
  endtask

  // Down wrap, level-chosen direction, then the clock output
  task automatic t_updown();
    logic [15:0] v;
    int n;
    wr(ADDR_MODE, 8'h81);
    wr(ADDR_RELOAD_HIGH, 8'h00);
    wr(ADDR_RELOAD_LOW, 8'h05);
    wr(ADDR_COUNT_HIGH, 8'h00);
    wr(ADDR_COUNT_LOW, 8'h08);
    trig_lvl = 1'b0;
    repeat (3) @(negedge sys_clk);
    wr(ADDR_CONTROL, 8'h04);
    n = 0;
    while (irq_req !== 1'b1 && n < 10) begin
      @(negedge sys_clk);
      n++;
    end
    chk("down wrap", 16'hFFFF, count_value);
    if (n >= 10) test_done();
    glb_en = 1'b0;
    @(negedge sys_clk);
    chk("irq global off", 16'h0000, {15'h0, irq_req});
    glb_en = 1'b1;
    wr(ADDR_CONTROL, 8'h00);
    trig_lvl = 1'b1;
    repeat (3) @(negedge sys_clk);
    v = count_value;
    wr(ADDR_CONTROL, 8'h04);
    wait_move(v, n);
    chk("up by level", v + 16'h0001, count_value);
    wr(ADDR_CONTROL, 8'h00);
    wr(ADDR_MODE, 8'h82);
    wr(ADDR_RELOAD_HIGH, 8'hFF);
    wr(ADDR_RELOAD_LOW, 8'hFC);
    wr(ADDR_COUNT_HIGH, 8'hFF);
    wr(ADDR_COUNT_LOW, 8'hFE);
    chk("clock out idle", 16'h0000, {15'h0, pin_out});
    wr(ADDR_CONTROL, 8'h04);
    n = 0;
    while (pin_out !== 1'b1 && n < 10) begin
      @(negedge sys_clk);
      n++;
    end
    if (n >= 10) begin
      bad_count++;
      test_done();
    end
    n = 0;
    while (pin_out !== 1'b0 && n < 10) begin
      @(negedge sys_clk);
      n++;
    end
    chk("clock half period", 16'd4, 16'(n));
    if (n >= 10) test_done();
    rdchk("no flag clock out", ADDR_CONTROL, 8'h04);
    wr(ADDR_CONTROL, 8'h00);
  endtask

  initial begin
    repeat (5) @(negedge sys_clk);
    rst = 1'b0;
    t_bank();
    t_prescale();
    t_overflow();
    t_capture();
    t_counter();
    t_updown();
    test_done();
  end
endmodule // tfc_timer_tb
